/* hw/mpsm_pkg.sv */
// constants, register map and state encodings for the mac power state manager
package mpsm_pkg;
  // clock and per-event times
  localparam int CLK_NS = 20;
  localparam int GUARD_NS = 1000;
  localparam int SIFS_NS = 2500;
  // least times round up to whole cycles
  localparam logic [15:0] GUARD_CYC = 16'((GUARD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SIFS_CYC = 8'((SIFS_NS + CLK_NS - 1) / CLK_NS);
  // superframe counts, neighbour count and field widths
  localparam logic [7:0] MAX_LOST = 8'h03;
  localparam logic [7:0] MAX_PROT = 8'h08;
  localparam logic [15:0] SCAN_SF = 16'h0001;
  localparam int NNB = 4;
  localparam int IDX_W = 2;
  localparam int CD_W = 8;
  localparam int DUR_W = 16;
  localparam int PWR_W = 8;
  // register byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_HCFG = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_NBR = 4'hc;
  // control fields
  localparam int CTRL_ANCHOR = 0;
  localparam int CTRL_HSTART = 1;
  localparam int CTRL_HWAKE = 2;
  // hibernation config fields
  localparam int HCFG_CD_LSB = 0;
  localparam int HCFG_DUR_LSB = 8;
  // status fields
  localparam int STAT_PWR_LSB = 0;
  localparam int STAT_HS_LSB = 8;
  localparam int STAT_AWAKE = 10;
  localparam int STAT_SLEEPOK = 11;
  localparam int STAT_REJOIN = 12;
  localparam int STAT_ERR = 13;
  localparam int STAT_CD_LSB = 16;
  // neighbour status fields, then the sifs counter load
  localparam int NBR_HIB_LSB = 0;
  localparam int NBR_LIST_LSB = 8;
  localparam logic [7:0] SIFS_LOAD = SIFS_CYC - 8'h02;
  typedef enum logic [1:0] {
    HS_ACTIVE = 2'b00,
    HS_ANNOUNCE = 2'b01,
    HS_HIB = 2'b10,
    HS_SCAN = 2'b11
  } mpsm_hib_t;
  typedef enum logic [1:0] {
    NS_IDLE = 2'b00,
    NS_ANN = 2'b01,
    NS_HIB = 2'b10
  } mpsm_nbr_t;
endpackage

/* hw/mpsm_nbr.sv */
// one neighbour's hibernation tracker with slot protection and anchor entry
`timescale 1ns/1ps
module mpsm_nbr (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sf_tick,
  input wire logic anchor_en,
  input wire logic own_bcn_tx,
  input wire logic bcn_seen,
  input wire logic bcn_hib_ie,
  input wire logic [7:0] bcn_cd,
  input wire logic [15:0] bcn_dur,
  output logic nb_hib,
  output logic slot_hold,
  output logic slot_named,
  output logic anc_list,
  output logic [15:0] anc_wake
);
  typedef struct packed {
    mpsm_pkg::mpsm_nbr_t st;
    logic seen;
    logic miss;
    logic [7:0] cd;
    logic [15:0] dur;
    logic [15:0] wake;
    logic [7:0] prot;
    logic listed;
  } mpsm_nbr_st_t;

  mpsm_nbr_st_t q;
  mpsm_nbr_st_t d;

  always_comb begin
    d = q;
    if (sf_tick) begin // R23
      d.seen = 1'b0;
      case (q.st)
        mpsm_pkg::NS_ANN: begin
          if (q.miss || (!q.seen && q.cd > mpsm_pkg::MAX_LOST)) begin
            // silent with a countdown above the lost limit: protect unnamed only
            d.miss = 1'b1; // R16
            d.prot = q.prot + 8'h01;
            if (q.prot == mpsm_pkg::MAX_PROT) begin
              d = '0;
            end
          end else if (q.cd == '0) begin
            // countdown of zero seen or reached: hibernation starts now
            d.st = mpsm_pkg::NS_HIB; // R14 R15 R22
            d.wake = q.dur; // R19
            d.listed = anchor_en; // R22
            d.miss = 1'b0;
            d.prot = '0;
          end else begin
            d.cd = q.cd - 8'h01;
          end
        end
        mpsm_pkg::NS_HIB: begin
          if (q.wake != '0) begin
            d.wake = q.wake - 16'h0001; // R19
          end else if (!q.seen) begin
            // past the announced end and still silent
            d.miss = 1'b1; // R16
            d.prot = q.prot + 8'h01;
            if (q.prot == mpsm_pkg::MAX_PROT) begin
              d = '0;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (own_bcn_tx && q.listed && q.wake == '0) begin
      d.listed = 1'b0; // R20
    end
    if (bcn_seen) begin
      d.seen = 1'b1;
      d.miss = 1'b0;
      d.prot = '0;
      d.listed = 1'b0; // R21
      d.cd = bcn_cd;
      d.dur = bcn_dur;
      d.st = bcn_hib_ie ? mpsm_pkg::NS_ANN : mpsm_pkg::NS_IDLE; // R14
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // hibernating: reservations ended, no traffic, unicast held back
  assign nb_hib = (q.st == mpsm_pkg::NS_HIB); // R14 R18
  assign slot_hold = nb_hib | q.miss; // R16 R17
  assign slot_named = nb_hib & ~q.miss; // R17
  assign anc_list = q.listed;
  assign anc_wake = q.wake;
endmodule

/* hw/mpsm_top.sv */
// mac power state manager: power cap, link feedback, sleep, hibernation, anchor
`timescale 1ns/1ps
// Contract
// R01: transmit power never exceeds the power of the last sent beacon.
// R02: answer link feedback request with response one SIFS after reception.
// R03: stay awake during discovery, antenna training or association; in HS_SCAN the code ignores discovery_busy.
// R04: sleep only after BP, between reservation blocks, or after session ends.
// R05: last frame of reservation: access one, more zero; none left: both zero.
// R06: be awake one guard time before every beacon period start.
// R07: with pending transmit frames, awake one guard time before each block.
// R08: with announced receptions, awake one guard time before that block.
// R09: announce hibernation in beacon with a non-zero duration.
// R10: countdown drops one per superframe; zero means hibernate next superframe.
// R11: hibernating sends nothing; tear reservations down beforehand.
// R12: hibernation may end early by sending a beacon.
// R13: scan the BP a superframe before waking; reuse slot or join afresh.
// R14: neighbour announcing hibernation: its reservations end, no traffic to it.
// R15: missed beacons after countdown within lost limit mean neighbour hibernates.
// R16: missing beacon: hold slot occupied unnamed until beacon or protection limit.
// R17: during neighbour hibernation keep its slot occupied and named.
// R18: buffer unicast for hibernating peers; do not delay group traffic.
// R19: anchor loads wake countdown from duration and decrements per superframe.
// R20: drop anchor entry after sending it at zero; omit element when empty.
// R21: beacon from hibernating neighbour removes its anchor entry next beacon.
// R22: anchor treats silent neighbour after low countdown as hibernating, lists it.
// R23: all superframe countdowns advance on the beacon period start strobe.
module mpsm_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bpst_tick,
  input wire logic in_bp,
  input wire logic [15:0] time_to_bpst,
  input wire logic in_rsv,
  input wire logic [15:0] time_to_rsv,
  input wire logic rsv_tx_pending,
  input wire logic rsv_rx_expected,
  input wire logic rsv_session_done,
  input wire logic discovery_busy,
  output logic awake,
  output logic sleep_ok,
  input wire logic bcn_tx,
  input wire logic [7:0] bcn_pwr,
  input wire logic [7:0] tx_pwr_req,
  output logic [7:0] tx_pwr,
  input wire logic lfb_req_rx,
  output logic lfb_rsp_tx,
  input wire logic fr_last_rsv,
  input wire logic fr_last_sf,
  output logic fr_access,
  output logic fr_more,
  output logic hib_ie_en,
  output logic [7:0] hib_ie_cd,
  output logic [15:0] hib_ie_dur,
  output logic tx_allow,
  output logic rsv_teardown,
  output logic scanning,
  input wire logic slot_free,
  output logic rejoin_fresh,
  input wire logic nb_bcn_valid,
  input wire logic [1:0] nb_idx,
  input wire logic nb_hib_ie,
  input wire logic [7:0] nb_cd,
  input wire logic [15:0] nb_dur,
  output logic [3:0] nb_hib,
  output logic [3:0] nb_slot_hold,
  output logic [3:0] nb_slot_named,
  output logic anc_ie_en,
  output logic [3:0] anc_list,
  output logic [63:0] anc_wake
);
  localparam int SIFS_DLY = int'(mpsm_pkg::SIFS_CYC);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic anchor_en;
    logic [7:0] cfg_cd;
    logic [15:0] cfg_dur;
    logic cfg_err;
    mpsm_pkg::mpsm_hib_t hs;
    logic [7:0] cd;
    logic [15:0] rem;
    logic rejoin;
    logic [7:0] bpwr;
    logic [7:0] txp;
    logic lfb_busy;
    logic [7:0] lfb_cnt;
    logic lfb_rsp;
    logic acc;
    logic more;
    logic awake;
    logic sleep_ok;
  } mpsm_st_t;

  mpsm_st_t q;
  mpsm_st_t d;
  logic [3:0] nb_seen;

  function automatic logic guard_due(input logic [15:0] t);
    guard_due = (t <= mpsm_pkg::GUARD_CYC);
  endfunction

  // neighbour trackers
  for (genvar i = 0; i < mpsm_pkg::NNB; i++) begin : g_nb
    assign nb_seen[i] = nb_bcn_valid && (nb_idx == mpsm_pkg::IDX_W'(i));
    mpsm_nbr u_nbr (
      .core_clk(core_clk),
      .resetn(resetn),
      .sf_tick(bpst_tick),
      .anchor_en(q.anchor_en),
      .own_bcn_tx(bcn_tx),
      .bcn_seen(nb_seen[i]),
      .bcn_hib_ie(nb_hib_ie),
      .bcn_cd(nb_cd),
      .bcn_dur(nb_dur),
      .nb_hib(nb_hib[i]),
      .slot_hold(nb_slot_hold[i]),
      .slot_named(nb_slot_named[i]),
      .anc_list(anc_list[i]),
      .anc_wake(anc_wake[i*mpsm_pkg::DUR_W +: mpsm_pkg::DUR_W])
    );
  end

  always_comb begin
    d = q;
    d.lfb_rsp = 1'b0;
    // avalon slave: one wait cycle, write and read data at the release edge
    d.ack = (avs_read | avs_write) & ~q.ack;
    if (avs_read && !q.ack) begin
      d.rdata = '0;
      case (avs_address)
        mpsm_pkg::ADDR_CTRL: d.rdata[mpsm_pkg::CTRL_ANCHOR] = q.anchor_en;
        mpsm_pkg::ADDR_HCFG: begin
          d.rdata[mpsm_pkg::HCFG_CD_LSB +: mpsm_pkg::CD_W] = q.cfg_cd;
          d.rdata[mpsm_pkg::HCFG_DUR_LSB +: mpsm_pkg::DUR_W] = q.cfg_dur;
        end
        mpsm_pkg::ADDR_STAT: begin
          d.rdata[mpsm_pkg::STAT_PWR_LSB +: mpsm_pkg::PWR_W] = q.bpwr;
          d.rdata[mpsm_pkg::STAT_HS_LSB +: 2] = q.hs;
          d.rdata[mpsm_pkg::STAT_AWAKE] = q.awake;
          d.rdata[mpsm_pkg::STAT_SLEEPOK] = q.sleep_ok;
          d.rdata[mpsm_pkg::STAT_REJOIN] = q.rejoin;
          d.rdata[mpsm_pkg::STAT_ERR] = q.cfg_err;
          d.rdata[mpsm_pkg::STAT_CD_LSB +: mpsm_pkg::CD_W] = q.cd;
        end
        mpsm_pkg::ADDR_NBR: begin
          d.rdata[mpsm_pkg::NBR_HIB_LSB +: mpsm_pkg::NNB] = nb_hib;
          d.rdata[mpsm_pkg::NBR_LIST_LSB +: mpsm_pkg::NNB] = anc_list;
        end
        default: d.rdata = '0;
      endcase
    end
    // announced duration stays fixed until hibernation is over
    if (avs_write && q.ack && avs_address == mpsm_pkg::ADDR_HCFG
        && q.hs == mpsm_pkg::HS_ACTIVE) begin // R09
      d.cfg_cd = avs_writedata[mpsm_pkg::HCFG_CD_LSB +: mpsm_pkg::CD_W];
      d.cfg_dur = avs_writedata[mpsm_pkg::HCFG_DUR_LSB +: mpsm_pkg::DUR_W];
    end
    if (avs_write && q.ack && avs_address == mpsm_pkg::ADDR_CTRL) begin
      d.anchor_en = avs_writedata[mpsm_pkg::CTRL_ANCHOR];
      if (avs_writedata[mpsm_pkg::CTRL_HSTART] && q.hs == mpsm_pkg::HS_ACTIVE) begin
        if (q.cfg_dur != '0) begin
          d.hs = mpsm_pkg::HS_ANNOUNCE; // R09
          d.cd = q.cfg_cd;
          d.cfg_err = 1'b0;
        end else begin
          d.cfg_err = 1'b1; // R09
        end
      end
      if (avs_writedata[mpsm_pkg::CTRL_HWAKE] && q.hs != mpsm_pkg::HS_ACTIVE) begin
        // early wake: own beacon goes out again from the next superframe
        d.hs = mpsm_pkg::HS_ACTIVE; // R12
        d.rejoin = 1'b0;
      end
    end
    // hibernation sequencing
    if (bpst_tick) begin // R23
      case (q.hs)
        mpsm_pkg::HS_ANNOUNCE: begin
          if (q.cd == '0) begin
            d.hs = mpsm_pkg::HS_HIB; // R10
            d.rem = q.cfg_dur;
          end else begin
            d.cd = q.cd - 8'h01; // R10
          end
        end
        mpsm_pkg::HS_HIB: begin
          d.rem = q.rem - 16'h0001;
          if (q.rem <= mpsm_pkg::SCAN_SF + mpsm_pkg::SCAN_SF) begin
            d.hs = mpsm_pkg::HS_SCAN; // R13
          end
        end
        mpsm_pkg::HS_SCAN: begin
          d.hs = mpsm_pkg::HS_ACTIVE; // R13
          d.rejoin = ~slot_free; // R13
        end
        default: begin
        end
      endcase
    end
    // power cap follows the beacon power that takes effect at this edge
    if (bcn_tx && q.hs != mpsm_pkg::HS_HIB) begin
      d.bpwr = bcn_pwr;
    end
    d.txp = (tx_pwr_req > d.bpwr) ? d.bpwr : tx_pwr_req; // R01
    // link feedback response one sifs after the request
    if (q.lfb_busy) begin
      if (q.lfb_cnt == '0) begin
        d.lfb_rsp = 1'b1; // R02
        d.lfb_busy = 1'b0;
      end else begin
        d.lfb_cnt = q.lfb_cnt - 8'h01;
      end
    end else if (lfb_req_rx && q.hs != mpsm_pkg::HS_HIB) begin
      d.lfb_busy = 1'b1; // R02
      d.lfb_cnt = mpsm_pkg::SIFS_LOAD;
    end
    // frame control fields for the next frame
    d.acc = fr_last_rsv & ~fr_last_sf; // R05
    d.more = ~(fr_last_rsv | fr_last_sf); // R05
    // sleep windows and wake-up points
    d.sleep_ok = ~discovery_busy & ~in_bp & (~in_rsv | rsv_session_done); // R03 R04
    case (q.hs)
      mpsm_pkg::HS_HIB: d.awake = discovery_busy; // R11
      mpsm_pkg::HS_SCAN: d.awake = in_bp | guard_due(time_to_bpst); // R13
      default: begin
        d.awake = ~d.sleep_ok // R04
          | guard_due(time_to_bpst) // R06
          | (rsv_tx_pending & (in_rsv | guard_due(time_to_rsv))) // R07
          | (rsv_rx_expected & (in_rsv | guard_due(time_to_rsv))); // R08
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
  assign avs_readdata = q.rdata;
  assign awake = q.awake;
  assign sleep_ok = q.sleep_ok;
  assign tx_pwr = q.txp;
  assign lfb_rsp_tx = q.lfb_rsp;
  assign fr_access = q.acc;
  assign fr_more = q.more;
  assign hib_ie_en = (q.hs == mpsm_pkg::HS_ANNOUNCE); // R09
  assign hib_ie_cd = q.cd;
  assign hib_ie_dur = q.cfg_dur;
  assign tx_allow = (q.hs == mpsm_pkg::HS_ACTIVE) | (q.hs == mpsm_pkg::HS_ANNOUNCE); // R11
  assign rsv_teardown = hib_ie_en & (q.cd == '0); // R11
  assign scanning = (q.hs == mpsm_pkg::HS_SCAN);
  assign rejoin_fresh = q.rejoin;
  assign anc_ie_en = q.anchor_en & (|anc_list); // R20

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  pwr_cap_a: assert property (tx_pwr <= q.bpwr) // R01
    else $error("transmit power above last beacon power");
  lfb_sifs_a: assert property ( // R02
    (lfb_req_rx && !q.lfb_busy && q.hs != mpsm_pkg::HS_HIB) |-> ##SIFS_DLY lfb_rsp_tx)
    else $error("link feedback response not one sifs after request");
  disc_awake_a: assert property ( // R03
    (discovery_busy && q.hs != mpsm_pkg::HS_SCAN) |=> awake)
    else $error("asleep during discovery");
  sleep_win_a: assert property ( // R04
    (in_bp && q.hs inside {mpsm_pkg::HS_ACTIVE, mpsm_pkg::HS_ANNOUNCE}) |=> awake && !sleep_ok)
    else $error("sleep outside allowed window");
  frm_flags_a: assert property ( // R05
    fr_last_sf |=> !fr_access && !fr_more)
    else $error("end of superframe flags wrong");
  bpst_guard_a: assert property ( // R06
    (time_to_bpst <= mpsm_pkg::GUARD_CYC && q.hs != mpsm_pkg::HS_HIB) |=> awake)
    else $error("not awake a guard time before beacon period");
  rsv_guard_a: assert property ( // R07
    (rsv_tx_pending && time_to_rsv <= mpsm_pkg::GUARD_CYC
     && q.hs inside {mpsm_pkg::HS_ACTIVE, mpsm_pkg::HS_ANNOUNCE}) |=> awake)
    else $error("not awake before transmit reservation");
  rx_guard_a: assert property ( // R08
    (rsv_rx_expected && time_to_rsv <= mpsm_pkg::GUARD_CYC
     && q.hs inside {mpsm_pkg::HS_ACTIVE, mpsm_pkg::HS_ANNOUNCE}) |=> awake)
    else $error("not awake before receive reservation");
  hib_dur_a: assert property (hib_ie_en |-> hib_ie_dur != '0) // R09
    else $error("hibernation announced with zero duration");
  hib_cd_a: assert property ( // R10
    (hib_ie_en && hib_ie_cd != '0 && bpst_tick && !avs_write) |=>
      hib_ie_en && hib_ie_cd == $past(hib_ie_cd) - 8'h01)
    else $error("hibernation countdown did not drop by one");
  hib_quiet_a: assert property ( // R11
    (hib_ie_en && hib_ie_cd == '0 && bpst_tick && !avs_write) |=>
      !tx_allow ##1 (!tx_allow && awake == $past(discovery_busy)))
    else $error("transmitting while hibernating");
  anc_omit_a: assert property (anc_ie_en |-> anc_list != '0) // R20
    else $error("anchor element with no entries");

  hib_enter_c: cover property (hib_ie_en ##1 !tx_allow);
  lfb_rsp_c: cover property (lfb_rsp_tx);
  anc_ie_c: cover property (anc_ie_en ##1 !anc_ie_en);
  rejoin_c: cover property (scanning ##1 rejoin_fresh);
endmodule

/* tb/mpsm_peer.sv */
// peer mac model: neighbour beacons and link feedback requests
`timescale 1ns/1ps
module mpsm_peer (
  input wire logic core_clk,
  output logic nb_bcn_valid,
  output logic [1:0] nb_idx,
  output logic nb_hib_ie,
  output logic [7:0] nb_cd,
  output logic [15:0] nb_dur,
  output logic lfb_req_rx
);
  initial begin
    nb_bcn_valid = 1'b0;
    nb_idx = 2'h0;
    nb_hib_ie = 1'b0;
    nb_cd = 8'h00;
    nb_dur = 16'h0000;
    lfb_req_rx = 1'b0;
  end

  // one beacon for one cycle; released fields show their inverse so stale data never matches
  task automatic send_bcn(input logic [1:0] idx, input logic hib, input logic [7:0] cd,
      input logic [15:0] dur);
    @(posedge core_clk);
    nb_bcn_valid <= 1'b1;
    nb_idx <= idx;
    nb_hib_ie <= hib;
    nb_cd <= cd;
    nb_dur <= dur;
    @(posedge core_clk);
    nb_bcn_valid <= 1'b0;
    nb_idx <= ~idx;
    nb_hib_ie <= ~hib;
    nb_cd <= ~cd;
    nb_dur <= ~dur;
    #1;
  endtask

  task automatic send_lfb();
    @(posedge core_clk);
    lfb_req_rx <= 1'b1;
    @(posedge core_clk);
    lfb_req_rx <= 1'b0;
  endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the mac power state manager
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic bpst_tick = 1'b0;
  logic in_bp = 1'b0;
  logic in_rsv = 1'b0;
  logic [15:0] time_to_bpst = 16'hffff;
  logic [15:0] time_to_rsv = 16'hffff;
  logic rsv_tx_pending = 1'b0;
  logic rsv_rx_expected = 1'b0;
  logic rsv_session_done = 1'b0;
  logic discovery_busy = 1'b0;
  logic bcn_tx = 1'b0;
  logic [7:0] bcn_pwr = 8'h0;
  logic [7:0] tx_pwr_req = 8'h0;
  logic fr_last_rsv = 1'b0;
  logic fr_last_sf = 1'b0;
  logic slot_free = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, awake, sleep_ok, lfb_rsp_tx, fr_access, fr_more, hib_ie_en;
  logic tx_allow, rsv_teardown, scanning, rejoin_fresh, anc_ie_en;
  logic nb_bcn_valid, nb_hib_ie, lfb_req_rx;
  logic [1:0] nb_idx;
  logic [7:0] tx_pwr, hib_ie_cd, nb_cd;
  logic [15:0] hib_ie_dur, nb_dur;
  logic [3:0] nb_hib, nb_slot_hold, nb_slot_named, anc_list;
  logic [63:0] anc_wake;
  logic [31:0] rd;
  int error_cnt = 0;
  int num_checks = 0;

  always #10 core_clk = ~core_clk;

  mpsm_top i_mpsm_top (.core_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .bpst_tick, .in_bp, .time_to_bpst,
    .in_rsv, .time_to_rsv, .rsv_tx_pending, .rsv_rx_expected, .rsv_session_done,
    .discovery_busy, .awake, .sleep_ok, .bcn_tx, .bcn_pwr, .tx_pwr_req, .tx_pwr,
    .lfb_req_rx, .lfb_rsp_tx, .fr_last_rsv, .fr_last_sf, .fr_access, .fr_more, .hib_ie_en,
    .hib_ie_cd, .hib_ie_dur, .tx_allow, .rsv_teardown, .scanning, .slot_free, .rejoin_fresh,
    .nb_bcn_valid, .nb_idx, .nb_hib_ie, .nb_cd, .nb_dur, .nb_hib, .nb_slot_hold,
    .nb_slot_named, .anc_ie_en, .anc_list, .anc_wake);

  mpsm_peer i_mpsm_peer (.core_clk, .nb_bcn_valid, .nb_idx, .nb_hib_ie, .nb_cd, .nb_dur,
    .lfb_req_rx);

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd,
      output logic [31:0] rdv);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  task automatic tick();
    @(posedge core_clk);
    bpst_tick <= 1'b1;
    @(posedge core_clk);
    bpst_tick <= 1'b0;
    #1;
  endtask

  task automatic t_regs();
    av(1'b0, mpsm_pkg::ADDR_STAT, 32'h0, rd);
    chk("stat reset", 32'h0, rd & 32'h0000_23ff);
    av(1'b0, mpsm_pkg::ADDR_NBR, 32'h0, rd);
    chk("nbr reset", 32'h0, rd);
    av(1'b1, mpsm_pkg::ADDR_CTRL, 32'h0000_0001, rd);
    av(1'b1, 4'h2, 32'hffff_ffff, rd);
    av(1'b0, 4'h2, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    av(1'b0, mpsm_pkg::ADDR_CTRL, 32'h0, rd);
    chk("ctrl", 32'h1, rd & 32'h0000_0003);
  endtask

  task automatic t_power();
    @(posedge core_clk);
    bcn_tx <= 1'b1;
    bcn_pwr <= 8'h40;
    tx_pwr_req <= 8'h50;
    @(posedge core_clk);
    bcn_tx <= 1'b0;
    bcn_pwr <= 8'hbf;
    tx_pwr_req <= 8'h20;
    #1;
    chk("tx_pwr capped", 32'h40, 32'(tx_pwr));
    @(posedge core_clk);
    bcn_tx <= 1'b1;
    bcn_pwr <= 8'h10;
    #1;
    chk("tx_pwr below cap", 32'h20, 32'(tx_pwr));
    @(posedge core_clk);
    bcn_tx <= 1'b0;
    #1;
    chk("tx_pwr lower beacon", 32'h10, 32'(tx_pwr));
    av(1'b0, mpsm_pkg::ADDR_STAT, 32'h0, rd);
    chk("beacon power", 32'h10, rd & 32'h0000_00ff);
  endtask

  task automatic t_lfb();
    int n;
    i_mpsm_peer.send_lfb();
    n = 1;
    #1;
    while (lfb_rsp_tx !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("lfb delay", 32'(mpsm_pkg::SIFS_CYC), 32'(n));
    if (n >= 300) print_verdict();
    @(posedge core_clk);
    #1;
    chk("lfb width", 32'h0, 32'(lfb_rsp_tx));
  endtask

  task automatic pw(input logic bp, input logic [15:0] tb, input logic [15:0] tr,
      input logic pend, input logic rxe, input logic disc, input logic exp);
    @(posedge core_clk);
    in_bp <= bp;
    time_to_bpst <= tb;
    time_to_rsv <= tr;
    rsv_tx_pending <= pend;
    rsv_rx_expected <= rxe;
    discovery_busy <= disc;
    @(posedge core_clk);
    #1;
    chk("awake", 32'(exp), 32'(awake));
  endtask

  task automatic t_awake();
    logic [15:0] g;
    g = mpsm_pkg::GUARD_CYC;
    pw(1'b0, 16'hffff, 16'hffff, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("sleep_ok", 32'h1, 32'(sleep_ok));
    pw(1'b1, 16'hffff, 16'hffff, 1'b0, 1'b0, 1'b0, 1'b1);
    pw(1'b0, g + 16'h1, 16'hffff, 1'b0, 1'b0, 1'b0, 1'b0);
    pw(1'b0, g, 16'hffff, 1'b0, 1'b0, 1'b0, 1'b1);
    pw(1'b0, 16'hffff, g + 16'h1, 1'b1, 1'b0, 1'b0, 1'b0);
    pw(1'b0, 16'hffff, g, 1'b1, 1'b0, 1'b0, 1'b1);
    pw(1'b0, 16'hffff, g, 1'b0, 1'b1, 1'b0, 1'b1);
    pw(1'b0, 16'hffff, g, 1'b0, 1'b0, 1'b0, 1'b0);
    pw(1'b0, 16'hffff, 16'hffff, 1'b0, 1'b0, 1'b1, 1'b1);
    pw(1'b0, 16'hffff, 16'hffff, 1'b0, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic fr(input logic lr, input logic ls, input logic ea, input logic em);
    @(posedge core_clk);
    fr_last_rsv <= lr;
    fr_last_sf <= ls;
    @(posedge core_clk);
    #1;
    chk("fr_access", 32'(ea), 32'(fr_access));
    chk("fr_more", 32'(em), 32'(fr_more));
  endtask

  task automatic t_hib();
    int n;
    av(1'b1, mpsm_pkg::ADDR_HCFG, 32'h0000_0502, rd);
    av(1'b1, mpsm_pkg::ADDR_CTRL, 32'h0000_0003, rd);
    @(posedge core_clk);
    #1;
    chk("hib ie", 32'h1, 32'(hib_ie_en));
    chk("hib dur", 32'h5, 32'(hib_ie_dur));
    chk("hib cd", 32'h2, 32'(hib_ie_cd));
    tick();
    chk("hib cd", 32'h1, 32'(hib_ie_cd));
    tick();
    chk("hib cd", 32'h0, 32'(hib_ie_cd));
    chk("teardown", 32'h1, 32'(rsv_teardown));
    tick();
    chk("tx_allow", 32'h0, 32'(tx_allow));
    i_mpsm_peer.send_lfb();
    n = 0;
    repeat (140) begin
      @(posedge core_clk);
      #1;
      if (lfb_rsp_tx === 1'b1) n++;
    end
    chk("lfb in hib", 32'h0, 32'(n));
    n = 0;
    while (scanning !== 1'b1 && n < 5) begin
      tick();
      n++;
    end
    chk("scanning", 32'h1, 32'(scanning));
    tick();
    chk("scan end", 32'h0, 32'(scanning));
    chk("rejoin", 32'h1, 32'(rejoin_fresh));
    chk("tx_allow", 32'h1, 32'(tx_allow));
  endtask

  task automatic t_early();
    av(1'b1, mpsm_pkg::ADDR_HCFG, 32'h0000_0900, rd);
    av(1'b1, mpsm_pkg::ADDR_CTRL, 32'h0000_0003, rd);
    tick();
    chk("tx_allow", 32'h0, 32'(tx_allow));
    av(1'b1, mpsm_pkg::ADDR_CTRL, 32'h0000_0005, rd);
    @(posedge core_clk);
    #1;
    chk("early wake", 32'h1, 32'(tx_allow));
    av(1'b1, mpsm_pkg::ADDR_HCFG, 32'h0000_0004, rd);
    av(1'b1, mpsm_pkg::ADDR_CTRL, 32'h0000_0003, rd);
    av(1'b0, mpsm_pkg::ADDR_STAT, 32'h0, rd);
    chk("zero duration", 32'h2000, rd & 32'h0000_2300);
  endtask

  task automatic t_nbr();
    int n;
    i_mpsm_peer.send_bcn(2'h1, 1'b1, 8'h01, 16'h0003);
    tick();
    i_mpsm_peer.send_bcn(2'h1, 1'b1, 8'h00, 16'h0003);
    tick();
    chk("nb_hib", 32'h1, 32'(nb_hib[1]));
    chk("anc_list", 32'h1, 32'(anc_list[1]));
    chk("anc_ie", 32'h1, 32'(anc_ie_en));
    chk("slot hold", 32'h1, 32'(nb_slot_hold[1]));
    chk("slot named", 32'h1, 32'(nb_slot_named[1]));
    chk("wake", 32'h3, 32'(anc_wake[31:16]));
    tick();
    chk("wake", 32'h2, 32'(anc_wake[31:16]));
    tick();
    tick();
    chk("wake", 32'h0, 32'(anc_wake[31:16]));
    chk("anc_list", 32'h1, 32'(anc_list[1]));
    @(posedge core_clk);
    bcn_tx <= 1'b1;
    @(posedge core_clk);
    bcn_tx <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("anc dropped", 32'h0, 32'(anc_list[1]));
    chk("anc_ie", 32'h0, 32'(anc_ie_en));
    i_mpsm_peer.send_bcn(2'h0, 1'b1, 8'h00, 16'h0014);
    tick();
    chk("nb_hib", 32'h1, 32'(nb_hib[0]));
    i_mpsm_peer.send_bcn(2'h0, 1'b0, 8'h00, 16'h0000);
    chk("nb back", 32'h0, 32'(nb_hib[0]));
    chk("anc removed", 32'h0, 32'(anc_list[0]));
    i_mpsm_peer.send_bcn(2'h2, 1'b1, 8'h05, 16'h0004);
    tick();
    tick();
    chk("hold", 32'h1, 32'(nb_slot_hold[2]));
    chk("unnamed", 32'h0, 32'(nb_slot_named[2]));
    repeat (mpsm_pkg::MAX_PROT + 1) tick();
    chk("hold expired", 32'h0, 32'(nb_slot_hold[2]));
    i_mpsm_peer.send_bcn(2'h3, 1'b1, 8'h02, 16'h0004);
    n = 0;
    while (nb_hib[3] !== 1'b1 && n < 4) begin
      tick();
      n++;
    end
    chk("silent hib", 32'h1, 32'(nb_hib[3]));
    chk("silent listed", 32'h1, 32'(anc_list[3]));
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_power();
    t_lfb();
    t_awake();
    fr(1'b1, 1'b0, 1'b1, 1'b0);
    fr(1'b0, 1'b1, 1'b0, 1'b0);
    fr(1'b0, 1'b0, 1'b0, 1'b1);
    t_hib();
    t_early();
    t_nbr();
    print_verdict();
  end

  initial begin
    #1500000;
    error_cnt++;
    print_verdict();
  end
endmodule
